// ===== rtl/fsw_watchdog.sv
`timescale 1ns/1ns

`include "fsw_regs.svh"

// Contract
// RULE1 - watchdog counts after every reset
// RULE2 - 13-bit prescaler on timer tick, 8-bit down timer
// RULE3 - select code picks divisor 32 to 4096
// RULE4 - zero plus decrement tick gives underflow, reload
// RULE5 - reload any 8-bit value, clears prescaler
// RULE6 - timeout equals tosc times N times P times W+1
// RULE7 - main timer loads on completed feed or watchdog reset
// RULE8 - software writes A5 then 5A back to back
// RULE9 - correct first key, wrong second key resets
// RULE10 - any access between feed writes resets
// RULE11 - software masks interrupts around feed
// RULE12 - control writes pend until valid feed
// RULE13 - disable: write zero control, then feed
// RULE14 - external reset sets defined watchdog state
// RULE15 - underflow during external reset leaves flag clear
// RULE16 - underflow reloads, sets flag, keeps settings
// RULE17 - watchdog reset restarts cpu, flag clearable
// RULE18 - reset state gives running timeout
// RULE19 - control: select 7..5, run 2, flag 1
// RULE20 - software loads reload then feeds
// RULE21 - software feeds within every timeout
// RULE22 - timer tick is oscillator over 4/16/64
// RULE23 - watchdog reset is one-cycle registered request
module fsw_watchdog
    import fsw_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [1:0] tick_sel,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [10:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    output logic wdt_reset_req,
    output logic wdt_running,
    output logic wdt_timeout_flag
);

    fsw_state_type q;
    fsw_state_type d;

    // decoded strobes
    logic any_access;
    logic wr_control;
    logic wr_reload;
    logic wr_feed1;
    logic wr_feed2;
    logic rd_control;
    logic rd_reload;

    // timing strobes
    logic [5:0] tick_lim;
    logic tick;
    logic [12:0] tap_mask;
    logic dec;

    // feed and underflow outcome
    logic feed_ok;
    logic feed_bad;
    logic underflow;
    logic autoload;
    logic wd_fire;

    // bus decode; any access anywhere counts for the feed check
    always_comb
    begin
        any_access = sfr_wr | sfr_rd;
        wr_control = sfr_wr && (sfr_addr == `FSW_ADDR_CONTROL);
        wr_reload = sfr_wr && (sfr_addr == `FSW_ADDR_RELOAD);
        wr_feed1 = sfr_wr && (sfr_addr == `FSW_ADDR_FEED1);
        wr_feed2 = sfr_wr && (sfr_addr == `FSW_ADDR_FEED2);
        rd_control = sfr_rd && (sfr_addr == `FSW_ADDR_CONTROL);
        rd_reload = sfr_rd && (sfr_addr == `FSW_ADDR_RELOAD);
    end

    // shared timer tick: oscillator over 4, 16 or 64
    always_comb
    begin
        case (tick_sel) // RULE22
            2'b00:
            begin
                tick_lim = `FSW_TICK_LIM_4;
            end
            2'b01:
            begin
                tick_lim = `FSW_TICK_LIM_16;
            end
            2'b10:
            begin
                tick_lim = `FSW_TICK_LIM_64;
            end
            default:
            begin
                // reserved code falls back to the fastest rate
                tick_lim = `FSW_TICK_LIM_4;
            end
        endcase
        // a lowered limit below the count just wraps once
        tick = (q.tick_div == tick_lim);
    end

    // decrement tap from the top eight prescaler stages
    always_comb
    begin
        // mask of the low stages below the selected tap
        tap_mask = (`FSW_TAP_BASE << q.tap_sel) - 13'h0001; // RULE3
        // one decrement per divisor ticks, only while running
        dec = q.run && tick && ((q.presc & tap_mask) == tap_mask); // RULE2
        underflow = dec && (q.main_cnt == 8'h00); // RULE4
    end

    // feed sequence checking
    always_comb
    begin
        feed_ok = 1'b0;
        feed_bad = 1'b0;
        case (q.feed)
            FSW_FEED_IDLE:
            begin
                feed_ok = 1'b0;
            end
            FSW_FEED_ARMED:
            begin
                if (wr_feed2 && (sfr_wdata == `FSW_KEY_SECOND))
                begin
                    feed_ok = 1'b1;
                end
                else if (wr_feed2)
                begin
                    feed_bad = q.run; // RULE9
                end
                else if (any_access)
                begin
                    // e.g. an interrupt handler touching a register
                    feed_bad = q.run; // RULE10
                end
            end
            default:
            begin
                feed_bad = 1'b0;
            end
        endcase
        // a violation acts like an underflow reset
        wd_fire = underflow | feed_bad;
        autoload = wd_fire | feed_ok; // RULE5
    end

    // next state
    always_comb
    begin
        d = q;

        // free-running tick divider
        d.tick_div = tick ? 6'h00 : q.tick_div + 6'h01;

        // prescaler counts timer ticks while running
        if (q.run && tick)
        begin
            d.presc = q.presc + 13'h0001; // RULE2
        end

        // main timer only counts down on decrement taps
        if (dec)
        begin
            d.main_cnt = q.main_cnt - 8'h01; // RULE6
        end

        // autoload wins over a decrement, clears prescaler
        if (autoload)
        begin
            d.main_cnt = q.reload; // RULE7
            d.presc = 13'h0000; // RULE5
        end

        // reload register is software-owned, never the timer
        if (wr_reload)
        begin
            d.reload = sfr_wdata; // RULE5
        end

        // control select and run writes only land in the pending copy
        if (wr_control)
        begin
            d.pend_sel = sfr_wdata[`FSW_CTL_SEL_MSB:`FSW_CTL_SEL_LSB];
            d.pend_run = sfr_wdata[`FSW_CTL_RUN_BIT]; // RULE12
        end

        // pending settings take effect on a good feed
        if (feed_ok)
        begin
            d.tap_sel = q.pend_sel; // RULE12
            d.run = q.pend_run; // RULE13
        end

        // flag: software clears by writing zero, set wins
        if (wr_control && !sfr_wdata[`FSW_CTL_TOF_BIT])
        begin
            d.tof = 1'b0; // RULE17
        end
        if (wd_fire)
        begin
            // run, reload and tap stay as they are
            d.tof = 1'b1; // RULE16
        end

        // feed sequencer
        case (q.feed)
            FSW_FEED_IDLE:
            begin
                // a wrong first key is simply ignored
                if (wr_feed1 && (sfr_wdata == `FSW_KEY_FIRST))
                begin
                    d.feed = FSW_FEED_ARMED;
                end
            end
            FSW_FEED_ARMED:
            begin
                // the access right after the first key ends it
                if (any_access)
                begin
                    d.feed = FSW_FEED_IDLE;
                end
            end
            default:
            begin
                d.feed = FSW_FEED_IDLE;
            end
        endcase

        // a watchdog reset also drops a half-done feed
        if (wd_fire)
        begin
            d.feed = FSW_FEED_IDLE;
        end

        // reset request one cycle after detection
        d.rst_req = wd_fire; // RULE23

        // registered read data, unmapped reads give zero
        if (rd_control)
        begin
            d.rdata = {q.tap_sel, 2'b00, q.run, q.tof, 1'b0}; // RULE19
        end
        else if (rd_reload)
        begin
            d.rdata = q.reload;
        end
        else
        begin
            d.rdata = 8'h00;
        end
    end

    // state register; external reset forces the running state
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            // async reset beats any underflow in flight
            q.tick_div <= 6'h00;
            q.presc <= 13'h0000; // RULE14
            q.main_cnt <= `FSW_RST_RELOAD; // RULE14
            q.reload <= `FSW_RST_RELOAD; // RULE14
            q.tap_sel <= `FSW_RST_SEL; // RULE18
            q.run <= `FSW_RST_RUN; // RULE1
            q.tof <= `FSW_RST_TOF; // RULE15
            q.pend_sel <= `FSW_RST_SEL;
            q.pend_run <= `FSW_RST_RUN;
            q.feed <= FSW_FEED_IDLE;
            q.rst_req <= 1'b0;
            q.rdata <= 8'h00;
        end
        else
        begin
            q <= d;
        end
    end

    // outputs straight from the state flops
    assign sfr_rdata = q.rdata;
    assign wdt_reset_req = q.rst_req; // RULE17
    assign wdt_running = q.run;
    assign wdt_timeout_flag = q.tof;

endmodule

// ===== rtl/fsw_regs.svh
`ifndef FSW_REGS_SVH
`define FSW_REGS_SVH

// special register addresses of the watchdog
`define FSW_ADDR_CONTROL 11'h45F
`define FSW_ADDR_RELOAD 11'h45B
`define FSW_ADDR_FEED1 11'h45D
`define FSW_ADDR_FEED2 11'h45E

// feed keys
`define FSW_KEY_FIRST 8'hA5
`define FSW_KEY_SECOND 8'h5A

// control register field positions
`define FSW_CTL_SEL_MSB 7
`define FSW_CTL_SEL_LSB 5
`define FSW_CTL_RUN_BIT 2
`define FSW_CTL_TOF_BIT 1

// reset values
`define FSW_RST_SEL 3'h7
`define FSW_RST_RUN 1'b1
`define FSW_RST_TOF 1'b0
`define FSW_RST_RELOAD 8'h00

// timer tick divider terminal counts (divisor minus one)
`define FSW_TICK_LIM_4 6'h03
`define FSW_TICK_LIM_16 6'h0F
`define FSW_TICK_LIM_64 6'h3F

// smallest tap divisor of the prescaler
`define FSW_TAP_BASE 13'h0020

`endif

// ===== rtl/fsw_pkg.sv
package fsw_pkg;

`include "fsw_regs.svh"

    // feed sequence progress
    typedef enum logic {
        FSW_FEED_IDLE,
        FSW_FEED_ARMED
    } fsw_feed_type;

    // complete state of the watchdog
    typedef struct packed {
        logic [5:0] tick_div;
        logic [12:0] presc;
        logic [7:0] main_cnt;
        logic [7:0] reload;
        logic [2:0] tap_sel;
        logic run;
        logic tof;
        logic [2:0] pend_sel;
        logic pend_run;
        fsw_feed_type feed;
        logic rst_req;
        logic [7:0] rdata;
    } fsw_state_type;

endpackage

// ===== tb/fsw_watchdog_properties.sv
`timescale 1ns/1ns
`include "fsw_regs.svh"
// pin-level checks of the watchdog
module fsw_watchdog_properties
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [1:0] tick_sel,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [10:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic wdt_reset_req,
    input wire logic wdt_running,
    input wire logic wdt_timeout_flag
);
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    // decodes of the feed keys and the control address
    wire logic key1 = sfr_wr && sfr_addr == `FSW_ADDR_FEED1
        && sfr_wdata == `FSW_KEY_FIRST;
    wire logic key2 = sfr_wr && sfr_addr == `FSW_ADDR_FEED2
        && sfr_wdata == `FSW_KEY_SECOND;
    wire logic ctl = sfr_addr == `FSW_ADDR_CONTROL;
    property p_pulse;
        wdt_reset_req |=> !wdt_reset_req;
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("reset request too long");
    property p_flag;
        wdt_reset_req |-> wdt_timeout_flag;
    endproperty
    a_flag: assert property (p_flag)
        else $error("reset without timeout flag");
    property p_ctl_rd;
        sfr_rd && ctl |=> sfr_rdata[2] == wdt_running
            && sfr_rdata[4:3] == 2'b00 && !sfr_rdata[0];
    endproperty
    a_ctl_rd: assert property (p_ctl_rd)
        else $error("control read layout wrong");
    property p_clear;
        sfr_wr && ctl && !sfr_wdata[1] ##1 !wdt_reset_req
            |-> !wdt_timeout_flag;
    endproperty
    a_clear: assert property (p_clear)
        else $error("flag not cleared by write");
    property p_bad;
        key1 && wdt_running ##1 (sfr_wr || sfr_rd) && !key2
            && !wdt_reset_req |=> wdt_reset_req;
    endproperty
    a_bad: assert property (p_bad)
        else $error("broken feed gave no reset");
    property p_run;
        !$stable(wdt_running) |-> $past(key2);
    endproperty
    a_run: assert property (p_run)
        else $error("run bit changed without feed");
    property p_stop;
        !$past(wdt_running) && !wdt_running |-> !wdt_reset_req;
    endproperty
    a_stop: assert property (p_stop)
        else $error("reset while stopped");
    property p_rst;
        disable iff (1'b0)
        rst |=> !wdt_reset_req && wdt_running && !wdt_timeout_flag;
    endproperty
    a_rst: assert property (p_rst)
        else $error("bad state in reset");
endmodule
bind fsw_watchdog fsw_watchdog_properties u_props (.clk_sys(clk_sys),
    .rst(rst), .tick_sel(tick_sel), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .wdt_reset_req(wdt_reset_req), .wdt_running(wdt_running),
    .wdt_timeout_flag(wdt_timeout_flag));

// ===== tb/tb.sv
`timescale 1ns/1ns
`include "fsw_regs.svh"
module tb;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [1:0] tick_sel = 2'h0;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic [10:0] sfr_addr = 11'h000;
    logic [7:0] sfr_wdata = 8'h00;
    logic [7:0] sfr_rdata;
    logic wdt_reset_req, wdt_running, wdt_timeout_flag;
    logic rd_q = 1'b0;
    logic [7:0] exp_q[$];
    logic [31:0] seed = 32'h0000_9F2F;
    int miscompares = 0;
    int n_tests = 0;
    int cyc = 0;
    int cnt, t, n, w, s, ps;
    fsw_watchdog dut (.clk_sys(clk_sys), .rst(rst), .tick_sel(tick_sel),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_addr(sfr_addr),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .wdt_reset_req(wdt_reset_req), .wdt_running(wdt_running),
        .wdt_timeout_flag(wdt_timeout_flag));
    initial
        forever #50 clk_sys = ~clk_sys;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(logic [15:0] got, logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: %h not %h", $time, got, exp);
        end
    endtask
    // one access per cycle; signals held until the next one
    task automatic acc(logic wr, logic [10:0] a, int d, int e);
        sfr_wr = wr;
        sfr_rd = !wr;
        sfr_addr = a;
        sfr_wdata = 8'(d);
        if (!wr)
            exp_q.push_back(8'(e));
        @(posedge clk_sys);
        #1;
    endtask
    // release the bus, count cycles until a reset request
    task automatic wait_req(int lim);
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        cnt = 0;
        while (wdt_reset_req !== 1'b1 && cnt < lim)
        begin
            @(posedge clk_sys);
            #1;
            cnt++;
        end
    endtask
    task automatic end_of_test();
        $display("%0d compares, %0d miscompares", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // read data lands one cycle after the read; also hang guard
    always @(posedge clk_sys)
    begin
        if (rd_q)
            check(sfr_rdata, exp_q.pop_front());
        rd_q <= sfr_rd;
        cyc++;
        if (cyc == 95000)
        begin
            miscompares++;
            end_of_test();
        end
    end
    initial
    begin
        repeat (5) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        acc(0, `FSW_ADDR_CONTROL, 0, 8'hE4);
        acc(0, `FSW_ADDR_RELOAD, 0, 0);
        acc(0, 11'h400, 0, 0);
        ps = 7;
        // every tap code; control write waits for the feed
        for (s = 0; s < 8; s++)
        begin
            w = rnd() & 1;
            tick_sel = (s < 2) ? 2'(rnd() % 3) : 2'h0;
            n = 4 << (2 * tick_sel);
            t = n * (32 << s) * (w + 1);
            // a lowered tick limit wraps once; let the divider settle
            wait_req(64);
            acc(1, `FSW_ADDR_RELOAD, w, 0);
            acc(1, `FSW_ADDR_CONTROL, s << 5 | 4, 0);
            acc(0, `FSW_ADDR_CONTROL, 0, ps << 5 | 4);
            acc(1, `FSW_ADDR_FEED1, `FSW_KEY_FIRST, 0);
            acc(1, `FSW_ADDR_FEED2, `FSW_KEY_SECOND, 0);
            acc(0, `FSW_ADDR_CONTROL, 0, s << 5 | 4);
            wait_req(40000);
            check(cnt + 1 >= t - n && cnt + 1 <= t + 2, 1);
            acc(0, `FSW_ADDR_CONTROL, 0, s << 5 | 6);
            acc(0, `FSW_ADDR_RELOAD, 0, w);
            ps = s;
        end
        // a stray read, then a wrong second key, between feed writes
        for (int k = 0; k < 2; k++)
        begin
            // clear the flag first so the violation must set it
            acc(1, `FSW_ADDR_CONTROL, 8'hE4, 0);
            check(wdt_timeout_flag, 0);
            acc(1, `FSW_ADDR_FEED1, `FSW_KEY_FIRST, 0);
            acc(k, k ? `FSW_ADDR_FEED2 : `FSW_ADDR_RELOAD, 0, w);
            check(wdt_reset_req, 1);
            check(wdt_timeout_flag, 1);
        end
        // switch off, then a broken feed must stay harmless
        acc(1, `FSW_ADDR_CONTROL, 0, 0);
        acc(1, `FSW_ADDR_FEED1, `FSW_KEY_FIRST, 0);
        acc(1, `FSW_ADDR_FEED2, `FSW_KEY_SECOND, 0);
        acc(0, `FSW_ADDR_CONTROL, 0, 0);
        acc(1, `FSW_ADDR_FEED1, `FSW_KEY_FIRST, 0);
        acc(1, `FSW_ADDR_FEED2, 0, 0);
        wait_req(400);
        check(cnt, 400);
        // a second reset restarts the watchdog
        rst = 1'b1;
        @(posedge clk_sys);
        #1;
        rst = 1'b0;
        acc(0, `FSW_ADDR_CONTROL, 0, 8'hE4);
        acc(0, `FSW_ADDR_RELOAD, 0, 0);
        wait_req(2);
        check(wdt_running, 1);
        end_of_test();
    end
endmodule
